/* File: rtl/bes_lane_decode.sv */
// big-endian lane decoder for one bus cycle of an access
`timescale 1ns/1ns
`default_nettype none
module bes_lane_decode
  import bes_pkg::*;
(
  bes_lane_if.dec lif
);
  wire [1:0] wlog;
  wire [1:0] plog;
  wire [3:0] wbytes;
  wire [3:0] pbytes;
  wire [2:0] off;
  wire [3:0] lo;
  wire [8:0] ones;
  wire [15:0] lanes;
  wire [1:0] last;
  wire [3:0] plo;

  assign wlog = width_log(lif.width);
  // a beat never carries more than the bus width
  assign plog = (lif.size < wlog) ? lif.size : wlog;
  assign wbytes = 4'h1 << wlog;
  assign pbytes = 4'h1 << plog;
  // beats beyond the first when the access is wider than the bus
  assign last = (lif.size > wlog) ?
      2'((4'h1 << (lif.size - wlog)) - 4'h1) : 2'h0;
  // offset within the bus, forced to the natural alignment of the piece
  assign off = lif.offset & 3'(wbytes - 4'h1) & ~3'(pbytes - 4'h1);
  // offset zero sits on the most significant lane
  assign lo = wbytes - pbytes - {1'b0, off};
  assign ones = 9'((9'h1 << pbytes) - 9'h1);
  // only the lanes of this piece are enabled
  assign lanes = {7'h0, ones} << lo;
  // most significant piece goes out first
  assign plo = 4'((last - lif.beat) * pbytes);

  assign lif.lane_en = lanes[7:0];
  assign lif.lane_lo = lo[2:0];
  assign lif.piece_lo = plo[2:0];
  assign lif.piece_log = plog;
  assign lif.last_beat = last;
endmodule // bes_lane_decode
`default_nettype wire

/* File: rtl/bes_lane_if.sv */
// lane decode request and answer between steering logic and decoder
`timescale 1ns/1ns
`default_nettype none
interface bes_lane_if;
  logic [1:0] width;
  logic [1:0] size;
  logic [2:0] offset;
  logic [1:0] beat;
  logic [7:0] lane_en;
  logic [2:0] lane_lo;
  logic [2:0] piece_lo;
  logic [1:0] piece_log;
  logic [1:0] last_beat;
  modport steer (output width, size, offset, beat,
                 input lane_en, lane_lo, piece_lo, piece_log, last_beat);
  modport dec (input width, size, offset, beat,
               output lane_en, lane_lo, piece_lo, piece_log, last_beat);
endinterface
`default_nettype wire

/* File: rtl/bes_lane_steer.sv */
// big-endian byte lane steering and strobe generation for external memory
`timescale 1ns/1ns
`default_nettype none
module bes_lane_steer
  import bes_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic endian_select_pin,
  input wire logic [1:0] ext_width,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic [63:0] req_wdata,
  output logic resp_valid,
  output logic [63:0] resp_rdata,
  output logic cyc_valid,
  output logic cyc_write,
  output logic [31:0] cyc_addr,
  output logic [63:0] cyc_wdata,
  input wire logic cyc_done,
  input wire logic [63:0] cyc_rdata,
  output logic [7:0] lane_write_strobe,
  output logic [7:0] lane_column_strobe,
  output logic [7:0] lane_data_mask,
  output logic bus_lock,
  output logic big_endian_mode
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BEAT = 2'b10
  } bes_state_e;

  bes_state_e state;
  bes_state_e next_state;
  logic mode_caught;
  logic [1:0] width;
  logic [1:0] size;
  logic [2:0] offset;
  logic [1:0] beat;
  logic [1:0] last_beat;
  logic [2:0] cur_lane_lo;
  logic [2:0] cur_piece_lo;
  logic [1:0] cur_plog;
  logic [63:0] acc_wdata;
  logic [63:0] acc_rdata;

  // decode request and answer share one carrier
  bes_lane_if lif();

  bes_lane_decode bes_lane_decode_inst (
    .lif(lif.dec)
  );

  // take needs idle and finish needs busy, so the two never meet
  wire is_idle = (state == ST_IDLE);
  wire take = is_idle && req_valid && req_ready;
  wire at_last = (beat == last_beat);
  wire beat_end = !is_idle && cyc_done;
  wire advance = beat_end && !at_last;
  wire finish = beat_end && at_last;
  wire load = take || advance;

  // decoder sees the new request when idle, else the following beat
  assign lif.width = is_idle ? ext_width : width;
  assign lif.size = is_idle ? req_size : size;
  assign lif.offset = is_idle ? req_addr[2:0] : offset;
  assign lif.beat = is_idle ? 2'h0 : 2'(beat + 2'h1);

  wire [63:0] src_wdata = is_idle ? req_wdata : acc_wdata;
  wire src_write = is_idle ? req_write : cyc_write;
  wire [63:0] pmask = piece_mask(lif.piece_log);
  wire [63:0] piece = (src_wdata >> {lif.piece_lo, 3'h0}) & pmask;
  wire [63:0] next_wdata = piece << {lif.lane_lo, 3'h0};
  // code 0 steps like 16-bit, matching the decoder's fallback
  wire [3:0] step = 4'h1 << width_log(width);
  wire [31:0] next_addr = is_idle ? req_addr : cyc_addr + {28'h0, step};
  // strobes of the coming beat; lanes outside the piece stay negated
  wire [7:0] next_col = lif.lane_en;
  wire [7:0] next_wstb = src_write ? next_col : LANES_IDLE;
  wire [7:0] next_mask = ~next_col;

  // read data: only the lanes of this beat are kept
  wire [63:0] rd_piece =
      (cyc_rdata >> {cur_lane_lo, 3'h0}) & piece_mask(cur_plog);
  wire [63:0] next_rdata = acc_rdata | (rd_piece << {cur_piece_lo, 3'h0});

  // no request until the endian mode has been caught
  assign req_ready = is_idle && mode_caught;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (take) next_state = ST_BEAT;
      ST_BEAT: if (finish) next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) state <= ST_IDLE;
    else state <= next_state;
  end

  // pin caught on the first edge after release, never under reset
  // little-endian is only reported; lane order stays big-endian
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_caught <= 1'b0;
      big_endian_mode <= 1'b1;
    end else if (!mode_caught) begin
      mode_caught <= 1'b1;
      big_endian_mode <= (endian_select_pin == PIN_BIG_ENDIAN);
    end
  end

  // access fields kept for the later beats
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      width <= WIDTH_64;
      size <= SIZE_BYTE;
      offset <= 3'h0;
      acc_wdata <= DATA_RESET;
    end else if (take) begin
      width <= ext_width;
      size <= req_size;
      offset <= req_addr[2:0];
      acc_wdata <= req_wdata;
    end
  end

  // per-beat registers; the next beat follows with no idle gap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      beat <= 2'h0;
      last_beat <= 2'h0;
      cur_lane_lo <= 3'h0;
      cur_piece_lo <= 3'h0;
      cur_plog <= SIZE_BYTE;
    end else if (load) begin
      beat <= lif.beat;
      last_beat <= lif.last_beat;
      cur_lane_lo <= lif.lane_lo;
      cur_piece_lo <= lif.piece_lo;
      cur_plog <= lif.piece_log;
    end
  end

  // beat address, direction and write data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_valid <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= ADDR_RESET;
      cyc_wdata <= DATA_RESET;
    end else if (load) begin
      cyc_valid <= 1'b1;
      cyc_write <= src_write;
      cyc_addr <= next_addr;
      cyc_wdata <= next_wdata;
    end else if (finish) begin
      cyc_valid <= 1'b0;
    end
  end

  // strobes fall with the last beat so no lane is left enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_write_strobe <= LANES_IDLE;
      lane_column_strobe <= LANES_IDLE;
      lane_data_mask <= MASK_IDLE;
    end else if (load) begin
      lane_column_strobe <= next_col;
      lane_write_strobe <= next_wstb;
      lane_data_mask <= next_mask;
    end else if (finish) begin
      lane_write_strobe <= LANES_IDLE;
      lane_column_strobe <= LANES_IDLE;
      lane_data_mask <= MASK_IDLE;
    end
  end

  // lock spans every beat of the access, so arbiter and refresh wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) bus_lock <= 1'b0;
    else if (take) bus_lock <= 1'b1;
    else if (finish) bus_lock <= 1'b0;
  end

  // reads gather beat by beat; writes only clear the collector at take
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) acc_rdata <= DATA_RESET;
    else if (take) acc_rdata <= DATA_RESET;
    else if (beat_end && !cyc_write) acc_rdata <= next_rdata;
  end

  // writes answer zero so stale read data never leaks out
  wire [63:0] next_resp = cyc_write ? DATA_RESET : next_rdata;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_valid <= 1'b0;
      resp_rdata <= DATA_RESET;
    end else begin
      resp_valid <= finish;
      if (finish) resp_rdata <= next_resp;
    end
  end
endmodule // bes_lane_steer
`default_nettype wire

/* File: rtl/bes_pkg.sv */
// constants shared by the big-endian lane steering block
package bes_pkg;
  // external data width codes (log2 of bus bytes)
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;
  localparam logic [1:0] WIDTH_64 = 2'h3;
  // access size codes (log2 of access bytes)
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_LONG = 2'h2;
  localparam logic [1:0] SIZE_QUAD = 2'h3;
  // endian select pin level that means big-endian
  localparam logic PIN_BIG_ENDIAN = 1'b0;
  // reset values
  localparam logic [7:0] LANES_IDLE = 8'h00;
  localparam logic [7:0] MASK_IDLE = 8'hff;
  localparam logic [63:0] DATA_RESET = 64'h0;
  localparam logic [31:0] ADDR_RESET = 32'h0;

  // bit mask covering 2**plog bytes
  function automatic logic [63:0] piece_mask(input logic [1:0] plog);
    logic [63:0] m;
    m = 64'h0;
    unique case (plog)
      2'h0: m = 64'h0000_0000_0000_00ff;
      2'h1: m = 64'h0000_0000_0000_ffff;
      2'h2: m = 64'h0000_0000_ffff_ffff;
      default: m = 64'hffff_ffff_ffff_ffff;
    endcase
    return m;
  endfunction

  // 8-bit bus code is not supported and is treated as 16-bit
  function automatic logic [1:0] width_log(input logic [1:0] w);
    return (w == 2'h0) ? WIDTH_16 : w;
  endfunction
endpackage

/* File: verification/bes_lane_steer_sva.sv */
// port assertions for the lane steering block
`timescale 1ns/1ns
`default_nettype none
module bes_lane_steer_sva
  import bes_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic endian_select_pin,
  input wire logic [1:0] ext_width,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [1:0] req_size,
  input wire logic [31:0] req_addr,
  input wire logic cyc_valid,
  input wire logic cyc_write,
  input wire logic [31:0] cyc_addr,
  input wire logic cyc_done,
  input wire logic [7:0] lane_write_strobe,
  input wire logic [7:0] lane_column_strobe,
  input wire logic [7:0] lane_data_mask,
  input wire logic bus_lock,
  input wire logic big_endian_mode
);
  // width, size and offset of the access in flight
  logic [6:0] acc;
  wire [1:0] wd = acc[6:5];
  wire [1:0] sz = acc[4:3];
  wire [2:0] off = acc[2:0];
  wire [7:0] col = lane_column_strobe;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) acc <= 7'h0;
    else if (req_valid && req_ready) acc <= {ext_width, req_size,
                                              req_addr[2:0]};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_mask;
    lane_data_mask == ~col && (cyc_valid || col == LANES_IDLE);
  endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_wstb;
    lane_write_strobe == (cyc_write ? col : LANES_IDLE);
  endproperty
  a_wstb: assert property (p_wstb) else $error("wstb");
  property p_l64;
    cyc_valid && wd == WIDTH_64 |->
      col == 8'(8'hff << (4'h8 - (4'h1 << sz))) >> off;
  endproperty
  a_l64: assert property (p_l64) else $error("l64");
  property p_l32;
    cyc_valid && wd == WIDTH_32 |-> col == (sz == SIZE_BYTE ?
      8'h08 >> off[1:0] : sz == SIZE_WORD ? 8'h0c >> off[1:0] : 8'h0f);
  endproperty
  a_l32: assert property (p_l32) else $error("l32");
  property p_l16;
    cyc_valid && wd == WIDTH_16 |->
      col == (sz == SIZE_BYTE ? 8'h02 >> off[0] : 8'h03);
  endproperty
  a_l16: assert property (p_l16) else $error("l16");
  property p_step;
    cyc_valid && cyc_done ##1 cyc_valid |->
      cyc_addr == $past(cyc_addr) + (32'h1 << wd);
  endproperty
  a_step: assert property (p_step) else $error("step");
  property p_lock;
    (cyc_valid |-> bus_lock) and ($fell(bus_lock) |-> $past(cyc_done));
  endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_mode;
    req_ready |-> big_endian_mode == (endian_select_pin == PIN_BIG_ENDIAN);
  endproperty
  a_mode: assert property (p_mode) else $error("mode");
endmodule // bes_lane_steer_sva
bind bes_lane_steer bes_lane_steer_sva bes_lane_steer_sva_inst (.clk,
  .rst_n, .endian_select_pin, .ext_width, .req_valid, .req_ready,
  .req_size, .req_addr, .cyc_valid, .cyc_write, .cyc_addr, .cyc_done,
  .lane_write_strobe, .lane_column_strobe, .lane_data_mask, .bus_lock,
  .big_endian_mode);
`default_nettype wire

/* File: verification/bes_lane_steer_tb.sv */
// self-checking bench for the lane steering block
`timescale 1ns/1ns
`default_nettype none
module bes_lane_steer_tb
  import bes_pkg::*;
;
  typedef struct packed {
    logic [1:0] w;
    logic [1:0] s;
    logic [7:0] a;
    logic [7:0] l;
    logic [3:0] n;
  } bes_row_s;
  localparam logic [63:0] PAT = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] WD = 64'hfedc_ba98_7654_3210;
  // width and size, offset, lanes, beats
  bes_row_s rows [20] = '{24'hc00801, 24'hc03101, 24'hc04081, 24'hc07011,
    24'hd02301, 24'hd06031, 24'he00f01, 24'he040f1, 24'hf00ff1, 24'h800081,
    24'h803011, 24'h902031, 24'ha000f1, 24'hb000f2, 24'h400021, 24'h401011,
    24'h500031, 24'h600032, 24'h700034, 24'h001011};
  logic clk, rst_n, endian_select_pin, req_valid, req_ready, req_write;
  logic resp_valid, cyc_valid, cyc_write, cyc_done, bus_lock, big_endian_mode;
  logic [1:0] ext_width, req_size;
  logic [3:0] lat;
  logic [31:0] req_addr, cyc_addr;
  logic [63:0] req_wdata, resp_rdata, cyc_wdata, cyc_rdata;
  logic [7:0] lane_write_strobe, lane_column_strobe, lane_data_mask;
  int errors, n_checks;
  bes_lane_steer bes_lane_steer_inst (.clk, .rst_n, .endian_select_pin,
    .ext_width, .req_valid, .req_ready, .req_write, .req_size, .req_addr,
    .req_wdata, .resp_valid, .resp_rdata, .cyc_valid, .cyc_write, .cyc_addr,
    .cyc_wdata, .cyc_done, .cyc_rdata, .lane_write_strobe,
    .lane_column_strobe, .lane_data_mask, .bus_lock, .big_endian_mode);
  bes_mem_model #(.PAT(PAT)) bes_mem_model_inst (.clk, .rst_n, .cyc_valid,
    .latency(lat), .cyc_done, .cyc_rdata);
  always #2 clk = ~clk;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, exp, input string what);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s %h %h", $time, what, got, exp);
      errors++;
    end
  endtask
  // 0 ready, 1 cycle done, 2 response
  task automatic wait_for(input int s);
    int k;
    logic v;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      v = s == 0 ? req_ready : s == 1 ? cyc_done : resp_valid;
    end while (v !== 1'b1 && k < 40);
    if (v !== 1'b1) begin
      chk(1'b0, 1'b1, "timeout");
      finish_test();
    end
  endtask
  task automatic run(input bes_row_s r, input logic wr);
    logic [63:0] wd, exp, pm, ew;
    int lo, pb;
    wd = WD & ~(64'hffff_ffff_ffff_ffff << (8 << r.s));
    pb = 8 * $countones(r.l);
    pm = ~(64'hffff_ffff_ffff_ffff << pb);
    lo = 0;
    while (!r.l[lo]) lo++;
    exp = 64'h0;
    @(posedge clk);
    ext_width <= r.w;
    req_size <= r.s;
    req_write <= wr;
    req_addr <= {24'h000100, r.a};
    req_wdata <= wd;
    req_valid <= 1'b1;
    wait_for(0);
    req_valid <= 1'b0;
    for (int k = 0; k < r.n; k++) begin
      wait_for(1);
      chk(cyc_addr, {24'h000100, r.a} + (k << r.w), "addr");
      chk(lane_column_strobe, r.l, "lanes");
      chk(lane_write_strobe, wr ? r.l : 8'h00, "wstb");
      chk(lane_data_mask, 8'(~r.l), "mask");
      chk({bus_lock, cyc_write}, {1'b1, wr}, "lock dir");
      ew = (wd >> (pb * (r.n - 1 - k)) & pm) << (8 * lo);
      if (wr) chk(cyc_wdata, ew, "wdata");
      exp = (exp << pb) | (PAT >> (8 * lo) & pm);
    end
    wait_for(2);
    chk(resp_rdata, wr ? 64'h0 : exp, "rdata");
    $display("test %h write %0d done", r, wr);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    endian_select_pin = PIN_BIG_ENDIAN;
    {req_valid, req_write, ext_width, req_size} = 6'h00;
    req_addr = 32'h0;
    req_wdata = 64'h0;
    lat = 4'h0;
    errors = 0;
    n_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wait_for(0);
    chk(big_endian_mode, 1'b1, "mode");
    // latency varies so beats see both prompt and stalled answers
    foreach (rows[i]) begin
      lat <= 4'(i % 3);
      run(rows[i], 1'b1);
      run(rows[i], 1'b0);
    end
    rst_n <= 1'b0;
    endian_select_pin <= 1'b1;
    @(posedge clk);
    chk(lane_column_strobe, LANES_IDLE, "rst col");
    chk(lane_data_mask, MASK_IDLE, "rst mask");
    chk({cyc_valid, bus_lock, resp_valid}, 3'h0, "rst idle");
    chk({req_ready, big_endian_mode}, 2'h1, "rst mode");
    @(posedge clk);
    rst_n <= 1'b1;
    wait_for(0);
    chk(big_endian_mode, 1'b0, "mode");
    $display("test reset done");
    run(rows[13], 1'b0);
    finish_test();
  end
endmodule // bes_lane_steer_tb
`default_nettype wire

/* File: verification/bes_mem_model.sv */
// memory timing model answering each bus cycle after a set latency
`timescale 1ns/1ns
`default_nettype none
module bes_mem_model #(
  parameter logic [63:0] PAT = 64'h0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cyc_valid,
  input wire logic [3:0] latency,
  output logic cyc_done,
  output logic [63:0] cyc_rdata
);
  logic [3:0] cnt;
  wire busy = cyc_valid && !cyc_done;
  // released lines show the inverse, never a stale copy
  assign cyc_rdata = cyc_done ? PAT : ~PAT;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      cyc_done <= 1'b0;
    end else begin
      cyc_done <= busy && cnt == latency;
      cnt <= busy && cnt != latency ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // bes_mem_model
`default_nettype wire
